/* File: shared/ass_map.svh */
// Register map and calibration constants of the analog setpoint scaler
`ifndef ASS_MAP_SVH
`define ASS_MAP_SVH
`define ASS_OFF_SEL 12'h000
`define ASS_OFF_FILT 12'h004
`define ASS_OFF_F1GAIN 12'h008
`define ASS_OFF_F2GAIN 12'h00C
`define ASS_OFF_F1BIAS 12'h010
`define ASS_OFF_L1BIAS 12'h014
`define ASS_OFF_L1GAIN 12'h018
`define ASS_OFF_F2BIAS 12'h01C
`define ASS_OFF_L2BIAS 12'h020
`define ASS_OFF_L2GAIN 12'h024
`define ASS_OFF_DISP 12'h028
`define ASS_OFF_ACCESS 12'h02C
`define ASS_OFF_STATUS 12'h030
`define ASS_OFF_LEVEL 12'h034
// Selector fields in SEL: [3:0] first input, [5:4] second input
`define ASS_SEL_AIN_LSB 0
`define ASS_SEL_T4_LSB 4
// ACCESS: [0] group read select, [1] write select
`define ASS_ACC_GRP_BIT 0
`define ASS_ACC_WR_BIT 1
// Reset values; frequency in 0.01 Hz, level in 0.1 percent
`define ASS_RST_AIN 4'h1
`define ASS_RST_T4 2'h0
`define ASS_RST_FILT 4'h1
`define ASS_RST_F1GAIN 16'h1388
`define ASS_RST_F2GAIN 16'h1388
`define ASS_RST_F1BIAS 16'h0000
`define ASS_RST_F2BIAS 16'h0000
`define ASS_RST_L1BIAS 16'h0000
`define ASS_RST_L1GAIN 16'h03E8
`define ASS_RST_L2BIAS 16'h00C8
`define ASS_RST_L2GAIN 16'h03E8
`define ASS_FREQ_MAX 16'h9C40
`define ASS_LEVEL_MAX 16'h0BB8
// Full scale 5 V equals 1000 permille; 10 V range doubles the level view scale
`define ASS_PERMILLE_FS 16'h03E8
// Filter step time 1 ms, cycles at 200 MHz
`define ASS_FILT_STEP_NS 1000000
`define ASS_CLK_NS 5
`define ASS_FILT_STEP_CYC (`ASS_FILT_STEP_NS / `ASS_CLK_NS)
`endif

/* File: shared/ass_pkg.sv */
// Types of the analog setpoint scaler
package ass_pkg;
  typedef enum logic [2:0] {
    ASS_IDLE = 3'b001,
    ASS_ADDR = 3'b010,
    ASS_DATA = 3'b100
  } ass_bus_e;
  typedef struct packed {
    logic [3:0] ain_sel;
    logic [1:0] t4_sel;
    logic [3:0] filt;
    logic [15:0] f1_gain;
    logic [15:0] f2_gain;
    logic [15:0] f1_bias;
    logic [15:0] l1_bias;
    logic [15:0] l1_gain;
    logic [15:0] f2_bias;
    logic [15:0] l2_bias;
    logic [15:0] l2_gain;
    logic disp_unit;
    logic grp_read;
    logic wr_sel;
  } ass_cfg_s;
  typedef struct packed {
    logic [15:0] freq;
    logic reverse;
  } ass_cmd_s;
endpackage : ass_pkg

/* File: verilog/ass_scaler.sv */
// Analog setpoint scaler with AHB-Lite register slave
// Function
// RULE1: Second input ignored unless enable asserted
// RULE2: Full scale maps to gain frequency
// RULE3: Select 0 or 10 gives 10V range
// RULE4: Second select 1/2 voltage when switch off
// RULE5: Select 10/11 enables reversible operation
// RULE6: Below calibrated midpoint commands reverse rotation
// RULE7: Second input reversible about bias default
// RULE8: First-order lag filter, setting 0 to 8
// RULE9: First gain frequency 0-400Hz, default 50Hz
// RULE10: Second gain frequency 0-400Hz, default 50Hz
// RULE11: First bias frequency 0-400Hz, default 0Hz
// RULE12: First levels 0-300%, defaults 0/100
// RULE13: Second levels 0-300%, defaults 20/100
// RULE14: Second bias frequency 0-400Hz
// RULE15: Display unit 0 percent, 1 V/mA
// RULE16: Display unit writable regardless of write select
// RULE17: Settings accessible only when group select 0
// RULE18: Gain frequency change acts immediately
// RULE19: Input select leaves acceleration slope alone
// RULE20: Below bias clamp to bias frequency
// RULE21: Above gain clamp to gain frequency
// RULE22: Linear interpolation between bias and gain
// RULE23: Enable selects second input as source
`include "ass_map.svh"
module ass_scaler #(
  parameter int ADC_W = 12,
  parameter int FILT_STEP_CYC = `ASS_FILT_STEP_CYC
) (
  input wire logic clk_sys_i,
  input wire logic rst_n_i,
  input wire logic hsel_i,
  input wire logic [31:0] haddr_i,
  input wire logic [1:0] htrans_i,
  input wire logic hwrite_i,
  input wire logic [2:0] hsize_i,
  input wire logic [31:0] hwdata_i,
  input wire logic hready_i,
  output logic [31:0] hrdata_o,
  output logic hreadyout_o,
  output logic hresp_o,
  input wire logic [ADC_W-1:0] first_level_i,
  input wire logic [ADC_W-1:0] second_level_i,
  input wire logic second_input_enable_i,
  input wire logic vi_switch_current_i,
  output logic [15:0] freq_cmd_o,
  output logic reverse_o,
  output logic second_active_o
);
  localparam logic [31:0] FS = 32'((1 << ADC_W) - 1);
  // Three-stage sync of pin level signals
  logic [2:0] en_sync_q, en_sync_d, sw_sync_q, sw_sync_d;
  logic en_q, en_d, sw_q, sw_d;
  always_comb begin
    en_sync_d = {en_sync_q[1:0], second_input_enable_i};
    sw_sync_d = {sw_sync_q[1:0], vi_switch_current_i};
    en_d = (en_sync_q[2] == en_sync_q[1]) ? en_sync_q[2] : en_q;
    sw_d = (sw_sync_q[2] == sw_sync_q[1]) ? sw_sync_q[2] : sw_q;
  end
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      en_sync_q <= 3'h0;
      sw_sync_q <= 3'h0;
      en_q <= 1'b0;
      sw_q <= 1'b0;
    end else begin
      en_sync_q <= en_sync_d;
      sw_sync_q <= sw_sync_d;
      en_q <= en_d;
      sw_q <= sw_d;
    end
  end

  // AHB-Lite slave, zero wait state
  ass_pkg::ass_cfg_s cfg_q, cfg_d;
  ass_pkg::ass_bus_e st_q, st_d;
  logic [11:0] addr_q, addr_d;
  logic wr_q, wr_d;
  logic [31:0] rdata_q, rdata_d;
  logic [31:0] level_view;
  logic [15:0] cmd_view;
  logic rev_view, src_view;
  logic take;
  assign take = hsel_i && hready_i && htrans_i[1];

  function automatic logic [15:0] lim(input logic [31:0] v,
                                      input logic [15:0] mx,
                                      input logic [15:0] old);
    lim = (v[31:16] == 16'h0000 && v[15:0] <= mx) ? v[15:0] : old;
  endfunction : lim

  always_comb begin
    st_d = take ? ass_pkg::ASS_DATA : ass_pkg::ASS_IDLE;
    addr_d = take ? haddr_i[11:0] : addr_q;
    wr_d = take && hwrite_i;
    cfg_d = cfg_q;
    rdata_d = 32'h0000_0000;
    if (st_q == ass_pkg::ASS_DATA && wr_q) begin
      // RULE16: Unit ignores write select
      if (addr_q == `ASS_OFF_DISP) begin
        cfg_d.disp_unit = hwdata_i[0];
      end
      if (addr_q == `ASS_OFF_ACCESS) begin
        cfg_d.grp_read = hwdata_i[`ASS_ACC_GRP_BIT];
        cfg_d.wr_sel = hwdata_i[`ASS_ACC_WR_BIT];
      end
      // RULE17: Gate by group select
      if (!cfg_q.grp_read) begin
        case (addr_q)
          `ASS_OFF_SEL: begin
            // RULE3: Only 0,1,10,11 accepted
            if (hwdata_i[3:0] == 4'h0 || hwdata_i[3:0] == 4'h1 ||
                hwdata_i[3:0] == 4'hA || hwdata_i[3:0] == 4'hB) begin
              cfg_d.ain_sel = hwdata_i[3:0];
            end
            if (hwdata_i[5:4] != 2'h3) begin
              cfg_d.t4_sel = hwdata_i[5:4];
            end
          end
          // RULE8: Setting 0 to 8
          `ASS_OFF_FILT: cfg_d.filt = (hwdata_i[3:0] <= 4'h8) ?
                                      hwdata_i[3:0] : cfg_q.filt;
          // RULE9: First gain range
          `ASS_OFF_F1GAIN: cfg_d.f1_gain = lim(hwdata_i, `ASS_FREQ_MAX,
                                               cfg_q.f1_gain);
          // RULE10: Second gain range
          `ASS_OFF_F2GAIN: cfg_d.f2_gain = lim(hwdata_i, `ASS_FREQ_MAX,
                                               cfg_q.f2_gain);
          // RULE11: First bias range
          `ASS_OFF_F1BIAS: cfg_d.f1_bias = lim(hwdata_i, `ASS_FREQ_MAX,
                                               cfg_q.f1_bias);
          // RULE12: First level ranges
          `ASS_OFF_L1BIAS: cfg_d.l1_bias = lim(hwdata_i, `ASS_LEVEL_MAX,
                                               cfg_q.l1_bias);
          `ASS_OFF_L1GAIN: cfg_d.l1_gain = lim(hwdata_i, `ASS_LEVEL_MAX,
                                               cfg_q.l1_gain);
          // RULE14: Second bias range
          `ASS_OFF_F2BIAS: cfg_d.f2_bias = lim(hwdata_i, `ASS_FREQ_MAX,
                                               cfg_q.f2_bias);
          // RULE13: Second level ranges
          `ASS_OFF_L2BIAS: cfg_d.l2_bias = lim(hwdata_i, `ASS_LEVEL_MAX,
                                               cfg_q.l2_bias);
          `ASS_OFF_L2GAIN: cfg_d.l2_gain = lim(hwdata_i, `ASS_LEVEL_MAX,
                                               cfg_q.l2_gain);
          default: ;
        endcase
      end
    end
    if (take && !hwrite_i) begin
      case (haddr_i[11:0])
        `ASS_OFF_SEL: rdata_d = {26'h0, cfg_q.t4_sel, cfg_q.ain_sel};
        `ASS_OFF_FILT: rdata_d = {28'h0, cfg_q.filt};
        `ASS_OFF_F1GAIN: rdata_d = {16'h0, cfg_q.f1_gain};
        `ASS_OFF_F2GAIN: rdata_d = {16'h0, cfg_q.f2_gain};
        `ASS_OFF_F1BIAS: rdata_d = {16'h0, cfg_q.f1_bias};
        `ASS_OFF_L1BIAS: rdata_d = {16'h0, cfg_q.l1_bias};
        `ASS_OFF_L1GAIN: rdata_d = {16'h0, cfg_q.l1_gain};
        `ASS_OFF_F2BIAS: rdata_d = {16'h0, cfg_q.f2_bias};
        `ASS_OFF_L2BIAS: rdata_d = {16'h0, cfg_q.l2_bias};
        `ASS_OFF_L2GAIN: rdata_d = {16'h0, cfg_q.l2_gain};
        `ASS_OFF_DISP: rdata_d = {31'h0, cfg_q.disp_unit};
        `ASS_OFF_ACCESS: rdata_d = {30'h0, cfg_q.wr_sel, cfg_q.grp_read};
        `ASS_OFF_STATUS: rdata_d = {14'h0, src_view, rev_view, cmd_view};
        `ASS_OFF_LEVEL: rdata_d = level_view;
        default: rdata_d = 32'h0000_0000;
      endcase
      // RULE17: Calibration reads as zero
      if (cfg_q.grp_read && haddr_i[11:0] <= `ASS_OFF_L2GAIN) begin
        rdata_d = 32'h0000_0000;
      end
    end
  end
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      st_q <= ass_pkg::ASS_IDLE;
      addr_q <= 12'h000;
      wr_q <= 1'b0;
      rdata_q <= 32'h0000_0000;
      cfg_q.ain_sel <= `ASS_RST_AIN;
      cfg_q.t4_sel <= `ASS_RST_T4;
      cfg_q.filt <= `ASS_RST_FILT;
      cfg_q.f1_gain <= `ASS_RST_F1GAIN;
      cfg_q.f2_gain <= `ASS_RST_F2GAIN;
      cfg_q.f1_bias <= `ASS_RST_F1BIAS;
      cfg_q.l1_bias <= `ASS_RST_L1BIAS;
      cfg_q.l1_gain <= `ASS_RST_L1GAIN;
      cfg_q.f2_bias <= `ASS_RST_F2BIAS;
      cfg_q.l2_bias <= `ASS_RST_L2BIAS;
      cfg_q.l2_gain <= `ASS_RST_L2GAIN;
      cfg_q.disp_unit <= 1'b0;
      cfg_q.grp_read <= 1'b0;
      cfg_q.wr_sel <= 1'b0;
    end else begin
      st_q <= st_d;
      addr_q <= addr_d;
      wr_q <= wr_d;
      rdata_q <= rdata_d;
      cfg_q <= cfg_d;
    end
  end
  assign hrdata_o = rdata_q;
  assign hreadyout_o = 1'b1;
  assign hresp_o = 1'b0;

  // RULE8: Lag filter, one step per tick
  logic [31:0] tick_q, tick_d;
  logic [ADC_W+8-1:0] acc_q [2], acc_d [2];
  logic [ADC_W-1:0] lvl [2];
  logic [ADC_W-1:0] raw [2];
  assign raw[0] = first_level_i;
  assign raw[1] = second_level_i;
  always_comb begin
    tick_d = (tick_q >= 32'(FILT_STEP_CYC - 1)) ? 32'h0 : tick_q + 32'h1;
  end
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      tick_q <= 32'h0;
    end else begin
      tick_q <= tick_d;
    end
  end
  // Settings 0..8 give a shift of 0..8 bits, about 1 ms to 0.25 s
  for (genvar g = 0; g < 2; g++) begin : g_filt
    logic [ADC_W+8-1:0] ext, dec;
    always_comb begin
      ext = {raw[g], 8'h00};
      dec = (cfg_q.filt == 4'h0) ? ext :
            acc_q[g] - (acc_q[g] >> cfg_q.filt) +
            (ext >> cfg_q.filt);
      acc_d[g] = (tick_q == 32'h0) ? dec : acc_q[g];
    end
    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
        acc_q[g] <= '0;
      end else begin
        acc_q[g] <= acc_d[g];
      end
    end
    assign lvl[g] = acc_q[g][ADC_W+8-1:8];
  end

  // Level in permille of 5 V; 10 V range doubles the scale
  logic wide1, wide2, rev_mode, use2;
  logic [31:0] pm1, pm2, pm, lb, lg, fb, fg, num, span, frac;
  logic [31:0] res;
  logic [15:0] cmd_d, cmd_q;
  logic rev_d, rev_q, src_d, src_q;
  always_comb begin
    // RULE3: 10 V range on 0 or 10
    wide1 = (cfg_q.ain_sel == 4'h0) || (cfg_q.ain_sel == 4'hA);
    // RULE4: Voltage ranges when switch off
    wide2 = !sw_q && cfg_q.t4_sel == 2'h2;
    // RULE5: Reversible on 10 or 11
    rev_mode = cfg_q.ain_sel[3];
    // RULE1: Second input only when enabled
    // RULE23: Source selection
    use2 = en_q;
    // RULE2: Full scale is 1000 permille
    pm1 = (32'(lvl[0]) * 32'(`ASS_PERMILLE_FS)) / FS;
    pm2 = (32'(lvl[1]) * 32'(`ASS_PERMILLE_FS)) / FS;
    pm = use2 ? pm2 : pm1;
    lb = use2 ? 32'(cfg_q.l2_bias) : 32'(cfg_q.l1_bias);
    lg = use2 ? 32'(cfg_q.l2_gain) : 32'(cfg_q.l1_gain);
    // RULE18: Gain frequency used live
    fb = use2 ? 32'(cfg_q.f2_bias) : 32'(cfg_q.f1_bias);
    fg = use2 ? 32'(cfg_q.f2_gain) : 32'(cfg_q.f1_gain);
    // No rescale by range: a level is already a
    // fraction of its selected range, so the range
    // only changes the level view further down
    frac = 32'h0;
    span = (lg > lb) ? lg - lb : 32'h1;
    num = 32'h0;
    res = fb;
    rev_d = 1'b0;
    // RULE20: Clamp below bias
    if (pm <= lb) begin
      res = fb;
    // RULE21: Clamp above gain
    end else if (pm >= lg) begin
      res = fg;
    end else begin
      // RULE22: Linear interpolation
      num = pm - lb;
      if (fg >= fb) begin
        res = fb + ((fg - fb) * num) / span;
      end else begin
        res = fb - ((fb - fg) * num) / span;
      end
    end
    // RULE6: Reverse below half the gain level
    // RULE7: Second input pivots on its bias
    if (rev_mode) begin
      if (use2) begin
        rev_d = pm < lb;
        frac = rev_d ? 32'(fg) * (lb - pm) / (lb == 32'h0 ? 32'h1 : lb)
                     : res;
      end else begin
        rev_d = (pm << 1) < lg;
        frac = rev_d ? 32'(fg) * (lg - (pm << 1)) / (lg == 32'h0 ? 32'h1 : lg)
                     : 32'(fg) * ((pm << 1) - lg) / (lg == 32'h0 ? 32'h1 : lg);
      end
      res = frac;
    end
    // RULE19: Slope untouched, only command out
    cmd_d = (res > 32'(`ASS_FREQ_MAX)) ? `ASS_FREQ_MAX : res[15:0];
    src_d = use2;
  end
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cmd_q <= 16'h0000;
      rev_q <= 1'b0;
      src_q <= 1'b0;
    end else begin
      cmd_q <= cmd_d;
      rev_q <= rev_d;
      src_q <= src_d;
    end
  end
  assign cmd_view = cmd_q;
  assign rev_view = rev_q;
  assign src_view = src_q;
  // RULE15: Level view in permille or millivolt/microamp
  always_comb begin
    if (!cfg_q.disp_unit) begin
      level_view = use2 ? pm2 : pm1;
    end else if (use2 && !sw_q && !wide2) begin
      level_view = pm2 * 32'h5;
    end else if (use2 ? (sw_q || cfg_q.t4_sel == 2'h0) : 1'b0) begin
      level_view = pm2 * 32'h14;
    end else begin
      level_view = (use2 ? pm2 : pm1) * ((use2 ? wide2 : wide1) ?
                   32'hA : 32'h5);
    end
  end
  assign freq_cmd_o = cmd_q;
  assign reverse_o = rev_q;
  assign second_active_o = src_q;
endmodule : ass_scaler

/* File: tb/ass_source_model.sv */
// Analog setpoint source feeding both sampled levels
module ass_source_model (
  input wire logic clk_i,
  input wire logic slow_i,
  input wire logic [11:0] t1_i,
  input wire logic [11:0] t2_i,
  output logic [11:0] lv1_o,
  output logic [11:0] lv2_o
);
  timeunit 1ns;
  timeprecision 1ps;
  // Slow mode slews like a turned knob, so the lag filter sees a ramp
  function automatic logic [11:0] step(logic [11:0] c, logic [11:0] t,
                                       logic s);
    if (!s || c == t) begin
      return t;
    end
    if (c < t) begin
      return (t - c > 12'h008) ? c + 12'h008 : t;
    end
    return (c - t > 12'h008) ? c - 12'h008 : t;
  endfunction : step
  initial lv1_o = 12'h000;
  initial lv2_o = 12'h000;
  always @(posedge clk_i) begin
    lv1_o <= step(lv1_o, t1_i, slow_i);
    lv2_o <= step(lv2_o, t2_i, slow_i);
  end
endmodule : ass_source_model

/* File: tb/ass_scaler_asserts.sv */
// Port checker of the setpoint scaler
`include "ass_map.svh"
module ass_scaler_asserts #(
  parameter int ADC_W = 12,
  parameter int FILT_STEP_CYC = `ASS_FILT_STEP_CYC
) (
  input wire logic clk_sys_i,
  input wire logic rst_n_i,
  input wire logic hsel_i,
  input wire logic [31:0] haddr_i,
  input wire logic [1:0] htrans_i,
  input wire logic hwrite_i,
  input wire logic hready_i,
  input wire logic [31:0] hrdata_o,
  input wire logic hreadyout_o,
  input wire logic hresp_o,
  input wire logic second_input_enable_i,
  input wire logic [15:0] freq_cmd_o,
  input wire logic reverse_o,
  input wire logic second_active_o
);
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!rst_n_i);
  property p_rdy; hreadyout_o; endproperty
  a_rdy: assert property (p_rdy) else $error("slave stalled");
  property p_okay; !hresp_o; endproperty
  a_okay: assert property (p_okay) else $error("error response");
  property p_src_on;
    $rose(second_input_enable_i) |-> ##[1:6] second_active_o;
  endproperty
  a_src_on: assert property (p_src_on) else $error("no switch");
  property p_src_off;
    $fell(second_input_enable_i) |-> ##[1:6] !second_active_o;
  endproperty
  a_src_off: assert property (p_src_off) else $error("no release");
  property p_src_hold;
    !second_input_enable_i [*8] |-> !second_active_o;
  endproperty
  a_src_hold: assert property (p_src_hold) else $error("stray src");
  property p_fmax; freq_cmd_o <= `ASS_FREQ_MAX; endproperty
  a_fmax: assert property (p_fmax) else $error("command too high");
  // Reads beyond the map must not leak stale data
  property p_unmap;
    hsel_i && hready_i && htrans_i[1] && !hwrite_i &&
    haddr_i[11:0] > `ASS_OFF_LEVEL |=> hrdata_o == 32'h0000_0000;
  endproperty
  a_unmap: assert property (p_unmap) else $error("unmapped data");
  property p_start;
    $rose(rst_n_i) |-> freq_cmd_o == 16'h0000 && !reverse_o;
  endproperty
  a_start: assert property (p_start) else $error("dirty start");
endmodule : ass_scaler_asserts
bind ass_scaler ass_scaler_asserts #(
  .ADC_W(ADC_W),
  .FILT_STEP_CYC(FILT_STEP_CYC)
) u_ass_scaler_asserts (
  .clk_sys_i(clk_sys_i),
  .rst_n_i(rst_n_i),
  .hsel_i(hsel_i),
  .haddr_i(haddr_i),
  .htrans_i(htrans_i),
  .hwrite_i(hwrite_i),
  .hready_i(hready_i),
  .hrdata_o(hrdata_o),
  .hreadyout_o(hreadyout_o),
  .hresp_o(hresp_o),
  .second_input_enable_i(second_input_enable_i),
  .freq_cmd_o(freq_cmd_o),
  .reverse_o(reverse_o),
  .second_active_o(second_active_o)
);

/* File: tb/ass_scaler_tb.sv */
// Register and command bench of the setpoint scaler
`include "ass_map.svh"
module ass_scaler_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_sys_i = 0, rst_n_i = 0, hsel = 0, hwrite = 0;
  logic en = 0, vi = 0, slow = 0, hrdy, hresp, rev, act;
  logic [31:0] haddr = 0, hwdata = 0, rd, hrdata;
  logic [1:0] htrans = 0;
  logic [2:0] hsize = 3'h2;
  logic [11:0] t1 = 0, t2 = 0, lv1, lv2;
  logic [15:0] fcmd;
  logic [3:0] modes [4] = '{4'h0, 4'h1, 4'hA, 4'hB};
  logic [15:0] rst_tab [11] = '{16'h0001, 16'h0001, 16'h1388, 16'h1388,
    16'h0000, 16'h0000, 16'h03E8, 16'h0000, 16'h00C8, 16'h03E8, 16'h0000};
  int n_fail = 0, n_tests = 0, cyc = 0;
  always #2.5 clk_sys_i = ~clk_sys_i;
  ass_source_model u_ass_source_model (.clk_i(clk_sys_i), .slow_i(slow),
    .t1_i(t1), .t2_i(t2), .lv1_o(lv1), .lv2_o(lv2));
  ass_scaler #(.ADC_W(12), .FILT_STEP_CYC(4)) u_ass_scaler (
    .clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .hsel_i(hsel),
    .haddr_i(haddr), .htrans_i(htrans), .hwrite_i(hwrite),
    .hsize_i(hsize), .hwdata_i(hwdata), .hready_i(hrdy),
    .hrdata_o(hrdata), .hreadyout_o(hrdy), .hresp_o(hresp),
    .first_level_i(lv1), .second_level_i(lv2),
    .second_input_enable_i(en), .vi_switch_current_i(vi),
    .freq_cmd_o(fcmd), .reverse_o(rev), .second_active_o(act));
  task automatic test_done();
    if (n_fail == 0 && n_tests > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : test_done
  // Hang guard, about twice the planned run
  always @(posedge clk_sys_i) begin
    cyc++;
    if (cyc == 60000) begin
      n_fail++;
      test_done();
    end
  end
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    n_tests++;
    if (s !== e) begin
      n_fail++;
      $display("wrong value at %0t: got %h want %h", $time, s, e);
    end
  endtask : chk
  task automatic bus(input logic w, input logic [11:0] a,
                     input logic [31:0] d);
    @(posedge clk_sys_i);
    haddr <= {20'h0_0000, a};
    htrans <= 2'h2;
    hwrite <= w;
    hsel <= 1'b1;
    do @(posedge clk_sys_i); while (hrdy !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge clk_sys_i); while (hrdy !== 1'b1);
    rd = hrdata;
  endtask : bus
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask : wr
  task automatic rchk(input logic [11:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0000_0000);
    chk(rd, e);
  endtask : rchk
  // Lag filter has no done flag; wait well past its settling time
  task automatic settle();
    repeat (3000) @(posedge clk_sys_i);
  endtask : settle
  task automatic near(input logic [15:0] lo, input logic [15:0] hi);
    chk({31'h0000_0000, fcmd >= lo && fcmd <= hi}, 32'h0000_0001);
  endtask : near
  initial begin
    repeat (16) @(posedge clk_sys_i);
    rst_n_i <= 1'b1;
    for (int i = 0; i < 11; i++) rchk(12'(i * 4), rst_tab[i]);
    rchk(12'h040, 32'h0000_0000);
    wr(`ASS_OFF_F1GAIN, 32'h0000_9C40);
    wr(`ASS_OFF_F1GAIN, 32'h0000_9C41);
    rchk(`ASS_OFF_F1GAIN, 32'h0000_9C40);
    wr(`ASS_OFF_L1GAIN, 32'h0000_0BB8);
    wr(`ASS_OFF_L1GAIN, 32'h0000_0BB9);
    rchk(`ASS_OFF_L1GAIN, 32'h0000_0BB8);
    wr(`ASS_OFF_FILT, 32'h0000_0008);
    wr(`ASS_OFF_FILT, 32'h0000_0009);
    rchk(`ASS_OFF_FILT, 32'h0000_0008);
    foreach (modes[i]) begin
      wr(`ASS_OFF_SEL, {28'h000_0000, modes[i]});
      rchk(`ASS_OFF_SEL, {28'h000_0000, modes[i]});
    end
    wr(`ASS_OFF_SEL, 32'h0000_0002);
    wr(`ASS_OFF_SEL, 32'h0000_003B);
    rchk(`ASS_OFF_SEL, 32'h0000_000B);
    wr(`ASS_OFF_ACCESS, 32'h0000_0001);
    rchk(`ASS_OFF_F1GAIN, 32'h0000_0000);
    wr(`ASS_OFF_F1GAIN, 32'h0000_1000);
    wr(`ASS_OFF_DISP, 32'h0000_0001);
    wr(`ASS_OFF_ACCESS, 32'h0000_0000);
    rchk(`ASS_OFF_F1GAIN, 32'h0000_9C40);
    rchk(`ASS_OFF_DISP, 32'h0000_0001);
    wr(`ASS_OFF_SEL, 32'h0000_0001);
    wr(`ASS_OFF_FILT, 32'h0000_0000);
    wr(`ASS_OFF_F1BIAS, 32'h0000_03E8);
    wr(`ASS_OFF_L1BIAS, 32'h0000_01F4);
    wr(`ASS_OFF_L1GAIN, 32'h0000_0320);
    wr(`ASS_OFF_F1GAIN, 32'h0000_2710);
    t1 <= 12'hFFF;
    settle();
    chk(fcmd, 16'h2710);
    rchk(`ASS_OFF_LEVEL, 32'h0000_1388);
    wr(`ASS_OFF_SEL, 32'h0000_0000);
    rchk(`ASS_OFF_LEVEL, 32'h0000_2710);
    chk(fcmd, 16'h2710);
    wr(`ASS_OFF_SEL, 32'h0000_0001);
    wr(`ASS_OFF_F1GAIN, 32'h0000_1388);
    repeat (20) @(posedge clk_sys_i);
    chk(fcmd, 16'h1388);
    slow <= 1'b1;
    t1 <= 12'h000;
    settle();
    chk(fcmd, 16'h03E8);
    wr(`ASS_OFF_FILT, 32'h0000_0008);
    t1 <= 12'hFFF;
    // Unfiltered, the ramp would reach gain within 520 cycles
    repeat (600) @(posedge clk_sys_i);
    chk(fcmd, 16'h03E8);
    wr(`ASS_OFF_FILT, 32'h0000_0000);
    t1 <= 12'hA8F;
    settle();
    near(16'h0C08, 16'h0C76);
    chk(rev, 1'b0);
    wr(`ASS_OFF_SEL, 32'h0000_0011);
    wr(`ASS_OFF_F2GAIN, 32'h0000_0FA0);
    wr(`ASS_OFF_L2GAIN, 32'h0000_0384);
    t2 <= 12'hFFF;
    settle();
    near(16'h0C08, 16'h0C76);
    en <= 1'b1;
    settle();
    chk(act, 1'b1);
    chk(fcmd, 16'h0FA0);
    rchk(`ASS_OFF_LEVEL, 32'h0000_1388);
    wr(`ASS_OFF_SEL, 32'h0000_0021);
    rchk(`ASS_OFF_LEVEL, 32'h0000_2710);
    en <= 1'b0;
    wr(`ASS_OFF_SEL, 32'h0000_000B);
    wr(`ASS_OFF_L1GAIN, 32'h0000_03E8);
    t1 <= 12'h000;
    settle();
    chk(act, 1'b0);
    chk(rev, 1'b1);
    t1 <= 12'hFFF;
    settle();
    chk(rev, 1'b0);
    vi <= 1'b1;
    en <= 1'b1;
    t2 <= 12'h000;
    settle();
    chk(rev, 1'b1);
    t2 <= 12'hFFF;
    settle();
    chk(rev, 1'b0);
    chk(fcmd, 16'h0FA0);
    rchk(`ASS_OFF_STATUS, 32'h0002_0FA0);
    rchk(`ASS_OFF_LEVEL, 32'h0000_4E20);
    wr(`ASS_OFF_DISP, 32'h0000_0000);
    rchk(`ASS_OFF_LEVEL, 32'h0000_03E8);
    test_done();
  end
endmodule : ass_scaler_tb
